// *** core/bgo_ctrl.v ***
// burst and gate oscillation sequencer with apb register file
`include "bgo_regs.vh"
`default_nettype none
module bgo_ctrl #(
	parameter CHANNEL_ID = 1'b0,
	parameter MARK_W = 16
) (
	// clock and reset
	input wire pclk,
	input wire presetn,
	// apb slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [31:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// trigger pins
	input wire ext_trig_in,
	input wire manual_trigger_key,
	// waveform control towards the synthesis datapath
	output reg osc_active,
	output reg [31:0] wave_phase,
	output reg hold_stop_level,
	output reg [7:0] stop_level,
	output reg [1:0] square_level,
	// indicators
	output reg sync_out,
	output reg trig_lamp,
	output reg trig_accept
);
	localparam ST_IDLE = 2'h0;
	localparam ST_DELAY = 2'h1;
	localparam ST_RUN = 2'h2;
	localparam ST_STOP = 2'h3;

	reg [31:0] ctrl_q;
	reg [31:0] freq_q;
	reg [31:0] phase_cfg_q;
	reg [MARK_W-1:0] mark_q;
	reg [31:0] tper_q;
	reg [31:0] tdly_q;
	reg [7:0] lvl_q;
	reg remote_q;
	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [MARK_W-1:0] cnt_q;
	reg [MARK_W-1:0] cnt_d;
	reg [31:0] dly_q;
	reg [31:0] dly_d;
	reg accept_d;
	reg [31:0] phase_q;
	reg [31:0] icnt_q;
	reg ext_s1_q, ext_s2_q, ext_s3_q, ext_lvl_q, ext_prev_q;
	reg man_s1_q, man_s2_q, man_s3_q, man_lvl_q, man_prev_q;
	reg [31:0] rd_d;
	reg hit;

	// configuration fields
	wire burst_en = ctrl_q[`BGO_C_BURST];
	wire gate_mode = ctrl_q[`BGO_C_GATE];
	wire idle_level_setting = ctrl_q[`BGO_C_IDLE_LVL];
	wire sync_output_select = ctrl_q[`BGO_C_SYNC_SEL];
	wire stop_unit_select = ctrl_q[`BGO_C_HALF];
	wire ext_src = ctrl_q[`BGO_C_EXT_SRC];
	wire [1:0] polarity = ctrl_q[`BGO_C_POL_HI:`BGO_C_POL_LO];
	wire [2:0] wave = ctrl_q[`BGO_C_WAVE_HI:`BGO_C_WAVE_LO];
	wire active_ch = ctrl_q[`BGO_C_ACT_CH];
	wire remote_gate = ctrl_q[`BGO_C_RGATE];
	wire is_noise = (wave == `BGO_WV_NOISE);
	wire is_dc = (wave == `BGO_WV_DC);
	wire is_square = (wave == `BGO_WV_SQUARE);

	// mode qualification
	wire trig_mode = burst_en & ~gate_mode &
		~is_noise & ~is_dc;
	wire gate_ok = burst_en & gate_mode & ~is_dc;
	wire conflict = burst_en & (gate_mode ? is_dc : (is_noise | is_dc));

	// apb slave, zero wait states
	wire [`BGO_AW-1:0] addr = paddr[`BGO_AW-1:0];
	wire wr_en = psel & penable & pwrite;
	wire [31:0] mark_ext = {{(32-MARK_W){1'b0}}, mark_q};
	wire [31:0] cnt_ext = {{(32-MARK_W){1'b0}}, cnt_q};
	wire running = (state_q == ST_RUN) | (state_q == ST_STOP);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~hit;

	always @* begin
		rd_d = 32'h0000_0000;
		hit = 1'b1;
		if (addr == `BGO_A_CTRL) begin
			rd_d = ctrl_q;
		end else if (addr == `BGO_A_FREQ) begin
			rd_d = freq_q;
		end else if (addr == `BGO_A_PHASE) begin
			rd_d = phase_cfg_q;
		end else if (addr == `BGO_A_MARK) begin
			rd_d = mark_ext;
		end else if (addr == `BGO_A_TPER) begin
			rd_d = tper_q;
		end else if (addr == `BGO_A_TDLY) begin
			rd_d = tdly_q;
		end else if (addr == `BGO_A_LEVEL) begin
			rd_d = {24'h00_0000, lvl_q};
		end else if (addr == `BGO_A_CMD) begin
			rd_d = 32'h0000_0000;
		end else if (addr == `BGO_A_STAT) begin
			rd_d[`BGO_S_RUN] = running;
			rd_d[`BGO_S_DELAY] = (state_q == ST_DELAY);
			rd_d[`BGO_S_LAMP] = trig_lamp;
			rd_d[`BGO_S_CONFLICT] = conflict;
			rd_d[31:`BGO_S_CNT_LO] = cnt_ext[31-`BGO_S_CNT_LO:0];
		end else begin
			hit = 1'b0;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `BGO_CTRL_RST;
			freq_q <= `BGO_FREQ_RST;
			phase_cfg_q <= `BGO_PHASE_RST;
			mark_q <= `BGO_MARK_RST;
			tper_q <= `BGO_TPER_RST;
			tdly_q <= `BGO_TDLY_RST;
			lvl_q <= `BGO_LEVEL_RST;
			remote_q <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			remote_q <= wr_en & (addr == `BGO_A_CMD) &
				pwdata[`BGO_CMD_TRIG];
			if (psel & ~penable) begin
				prdata <= rd_d;
			end
			if (wr_en) begin
				if (addr == `BGO_A_CTRL) begin
					ctrl_q <= pwdata & `BGO_CTRL_MASK;
				end else if (addr == `BGO_A_FREQ) begin
					freq_q <= pwdata;
				end else if (addr == `BGO_A_PHASE) begin
					phase_cfg_q <= pwdata;
				end else if (addr == `BGO_A_MARK) begin
					mark_q <= pwdata[MARK_W-1:0];
				end else if (addr == `BGO_A_TPER) begin
					tper_q <= pwdata;
				end else if (addr == `BGO_A_TDLY) begin
					tdly_q <= pwdata;
				end else if (addr == `BGO_A_LEVEL) begin
					lvl_q <= pwdata[7:0];
				end
			end
		end
	end

	// pin synchronisers, a change counts once stages two and three agree
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
			ext_lvl_q <= 1'b0;
			ext_prev_q <= 1'b0;
			man_s1_q <= 1'b0;
			man_s2_q <= 1'b0;
			man_s3_q <= 1'b0;
			man_lvl_q <= 1'b0;
			man_prev_q <= 1'b0;
		end else begin
			ext_s1_q <= ext_trig_in;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
			if (ext_s2_q == ext_s3_q) begin
				ext_lvl_q <= ext_s3_q;
			end
			ext_prev_q <= ext_lvl_q;
			man_s1_q <= manual_trigger_key;
			man_s2_q <= man_s1_q;
			man_s3_q <= man_s2_q;
			if (man_s2_q == man_s3_q) begin
				man_lvl_q <= man_s3_q;
			end
			man_prev_q <= man_lvl_q;
		end
	end

	// internal trigger oscillator
	wire int_wrap = (icnt_q >= tper_q - 32'h0000_0001);
	wire int_pulse = int_wrap & (tper_q != 32'h0000_0000);
	wire int_gate = (icnt_q < (tper_q >> 1));

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			icnt_q <= 32'h0000_0000;
		end else if (int_wrap) begin
			icnt_q <= 32'h0000_0000;
		end else begin
			icnt_q <= icnt_q + 32'h0000_0001;
		end
	end

	// trigger and gate sources
	wire ext_rise = ext_lvl_q & ~ext_prev_q;
	wire ext_fall = ~ext_lvl_q & ext_prev_q;
	wire ext_pulse = ((polarity == `BGO_POL_RISE) & ext_rise) |
		((polarity == `BGO_POL_FALL) & ext_fall);
	wire ext_gate = ((polarity == `BGO_POL_RISE) & ext_lvl_q) |
		((polarity == `BGO_POL_FALL) & ~ext_lvl_q);
	wire man_mine = (active_ch == CHANNEL_ID);
	wire man_pulse = man_mine & man_lvl_q & ~man_prev_q;
	wire man_gate = man_mine & man_lvl_q;
	wire del_pulse = ext_src ? ext_pulse : int_pulse;
	wire imm_pulse = man_pulse | remote_q;
	wire src_gate = ext_src ? ext_gate : int_gate;
	wire gate_on = src_gate | man_gate | remote_gate;

	// phase crossings relative to the start/stop phase
	wire [31:0] phase_nx = phase_q + freq_q;
	wire [31:0] rel_now = phase_q - phase_cfg_q;
	wire [31:0] rel_nx = phase_nx - phase_cfg_q;
	wire half_x = running & (rel_now[31] ^ rel_nx[31]);
	wire full_x = running & rel_now[31] & ~rel_nx[31];
	wire stop_hit = stop_unit_select ? half_x : full_x;

	always @* begin
		state_d = state_q;
		cnt_d = cnt_q;
		dly_d = dly_q;
		accept_d = 1'b0;
		case (state_q)
			ST_IDLE: begin
				if (trig_mode & (mark_q != {MARK_W{1'b0}}) &
					imm_pulse) begin
					state_d = ST_RUN;
					cnt_d = mark_q;
					accept_d = 1'b1;
				end else if (trig_mode & (mark_q != {MARK_W{1'b0}}) &
					del_pulse) begin
					accept_d = 1'b1;
					cnt_d = mark_q;
					if (tdly_q == 32'h0000_0000) begin
						state_d = ST_RUN;
					end else begin
						state_d = ST_DELAY;
						dly_d = tdly_q - 32'h0000_0001;
					end
				end else if (gate_ok & gate_on) begin
					state_d = ST_RUN;
				end
			end
			ST_DELAY: begin
				if (!trig_mode) begin
					state_d = ST_IDLE;
				end else if (dly_q == 32'h0000_0000) begin
					state_d = ST_RUN;
				end else begin
					dly_d = dly_q - 32'h0000_0001;
				end
			end
			ST_RUN: begin
				if (!(trig_mode | gate_ok)) begin
					state_d = ST_IDLE;
				end else if (!gate_mode) begin
					if (half_x) begin
						cnt_d = cnt_q - {{(MARK_W-1){1'b0}}, 1'b1};
						if (cnt_q == {{(MARK_W-1){1'b0}}, 1'b1}) begin
							state_d = ST_IDLE;
						end
					end
				end else if (!gate_on) begin
					if (is_noise | stop_hit) begin
						state_d = ST_IDLE;
					end else begin
						state_d = ST_STOP;
					end
				end
			end
			ST_STOP: begin
				if (!gate_ok) begin
					state_d = ST_IDLE;
				end else if (gate_on) begin
					state_d = ST_RUN;
				end else if (stop_hit) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_IDLE;
			cnt_q <= {MARK_W{1'b0}};
			dly_q <= 32'h0000_0000;
			phase_q <= 32'h0000_0000;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			dly_q <= dly_d;
			// idle parks the accumulator on the start/stop phase
			if (running) begin
				phase_q <= phase_nx;
			end else begin
				phase_q <= phase_cfg_q;
			end
		end
	end

	// registered outputs
	wire stopped = ~running;
	wire hold_d = stopped & (idle_level_setting | is_noise);
	reg [1:0] sq_d;
	always @* begin
		if (hold_d) begin
			sq_d = `BGO_SQ_STOP;
		end else if (phase_q[31]) begin
			sq_d = `BGO_SQ_LOW;
		end else begin
			sq_d = `BGO_SQ_HIGH;
		end
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_active <= 1'b0;
			wave_phase <= 32'h0000_0000;
			hold_stop_level <= 1'b0;
			stop_level <= `BGO_LEVEL_RST;
			square_level <= `BGO_SQ_HIGH;
			sync_out <= 1'b1;
			trig_lamp <= 1'b0;
			trig_accept <= 1'b0;
		end else begin
			osc_active <= running;
			wave_phase <= phase_q;
			hold_stop_level <= hold_d;
			stop_level <= lvl_q;
			square_level <= is_square ? sq_d : `BGO_SQ_STOP;
			if (sync_output_select) begin
				sync_out <= stopped;
			end else begin
				sync_out <= ~phase_q[31];
			end
			trig_accept <= accept_d;
			trig_lamp <= (~gate_mode & (state_d != ST_IDLE)) |
				(gate_ok & gate_on);
		end
	end
endmodule
`default_nettype wire

// *** core/bgo_regs.vh ***
// register map, fields, codes and reset values of the burst/gate sequencer
`ifndef BGO_REGS_VH
`define BGO_REGS_VH
// byte addresses, low 12 bits of paddr
`define BGO_AW 12
`define BGO_A_CTRL 12'h000
`define BGO_A_FREQ 12'h004
`define BGO_A_PHASE 12'h008
`define BGO_A_MARK 12'h00c
`define BGO_A_TPER 12'h010
`define BGO_A_TDLY 12'h014
`define BGO_A_LEVEL 12'h018
`define BGO_A_CMD 12'h01c
`define BGO_A_STAT 12'h020
// control fields
`define BGO_C_BURST 0
`define BGO_C_GATE 1
`define BGO_C_IDLE_LVL 2
`define BGO_C_SYNC_SEL 3
`define BGO_C_HALF 4
`define BGO_C_EXT_SRC 5
`define BGO_C_POL_LO 6
`define BGO_C_POL_HI 7
`define BGO_C_WAVE_LO 8
`define BGO_C_WAVE_HI 10
`define BGO_C_ACT_CH 11
`define BGO_C_RGATE 12
`define BGO_CTRL_MASK 32'h0000_1fff
// command fields
`define BGO_CMD_TRIG 0
// status fields
`define BGO_S_RUN 0
`define BGO_S_DELAY 1
`define BGO_S_LAMP 2
`define BGO_S_CONFLICT 3
`define BGO_S_CNT_LO 16
// external trigger polarity codes
`define BGO_POL_OFF 2'h0
`define BGO_POL_RISE 2'h1
`define BGO_POL_FALL 2'h2
// waveform codes
`define BGO_WV_SINE 3'h0
`define BGO_WV_SQUARE 3'h1
`define BGO_WV_NOISE 3'h2
`define BGO_WV_DC 3'h3
// square output levels
`define BGO_SQ_STOP 2'h0
`define BGO_SQ_HIGH 2'h1
`define BGO_SQ_LOW 2'h2
// reset values
`define BGO_CTRL_RST 32'h0000_0000
`define BGO_FREQ_RST 32'h0100_0000
`define BGO_PHASE_RST 32'h0000_0000
`define BGO_MARK_RST 16'h0002
`define BGO_TPER_RST 32'h0001_86a0
`define BGO_TDLY_RST 32'h0000_0000
`define BGO_LEVEL_RST 8'h00
`endif

// *** test/bgo_ctrl_checker.sv ***
// port assertions for the burst/gate sequencer
`include "bgo_regs.vh"
`default_nettype none
module bgo_ctrl_checker (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	// sequencer outputs
	input wire logic osc_active,
	input wire logic [31:0] wave_phase,
	input wire logic hold_stop_level,
	input wire logic sync_out,
	input wire logic trig_lamp,
	input wire logic trig_accept
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] ctrl_q;
	logic [31:0] phase_q;
	wire logic wr = psel && penable && pwrite;
	wire logic sync_sel = ctrl_q[`BGO_C_SYNC_SEL];
	// shadow of control and phase writes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= `BGO_CTRL_RST;
			phase_q <= `BGO_PHASE_RST;
		end else if (wr && paddr[11:0] == `BGO_A_CTRL) begin
			ctrl_q <= pwdata;
		end else if (wr && paddr[11:0] == `BGO_A_PHASE) begin
			phase_q <= pwdata;
		end
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence s_start;
		##[0:300] $rose(osc_active);
	endsequence
	sequence s_idle_lvl;
		(!osc_active && ctrl_q[`BGO_C_IDLE_LVL])[*3];
	endsequence
	chk_accept_pulse: assert property (
		trig_accept |=> !trig_accept) else $error("accept too long");
	chk_accept_lamp: assert property (
		trig_accept |-> ##[0:1] trig_lamp) else $error("lamp missing");
	chk_accept_start: assert property (
		trig_accept |-> s_start) else $error("burst never started");
	chk_no_retrig: assert property (
		osc_active && $past(osc_active) |-> !trig_accept)
		else $error("trigger taken during burst");
	chk_start_phase: assert property (
		$rose(osc_active) |-> wave_phase == phase_q)
		else $error("start phase wrong");
	chk_sync_burst: assert property (
		(sync_sel && $stable(osc_active))[*2] |-> sync_out == !osc_active)
		else $error("burst sync wrong");
	chk_sync_ref: assert property (
		(!sync_sel)[*2] |-> sync_out == !wave_phase[31]
		|| sync_out == !$past(wave_phase[31])) else $error("ref sync wrong");
	chk_idle_level: assert property (
		s_idle_lvl |-> hold_stop_level) else $error("stop level not held");
endmodule
bind bgo_ctrl bgo_ctrl_checker u_chk (.pclk, .presetn, .psel, .penable,
	.pwrite, .paddr, .pwdata, .osc_active, .wave_phase, .hold_stop_level,
	.sync_out, .trig_lamp, .trig_accept);
`default_nettype wire

// *** test/bgo_partner.sv ***
// external trigger source and trigger key, driven on bench command
`default_nettype none
module bgo_partner (
	// clock
	input wire logic pclk,
	// trigger pins
	output logic ext_trig_in,
	output logic manual_trigger_key
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		ext_trig_in = 1'b0;
		manual_trigger_key = 1'b0;
	end
	// logic-level pulse held n clocks, then back to rest
	task automatic pulse(input bit key, input int n);
		if (key)
			manual_trigger_key <= 1'b1;
		else
			ext_trig_in <= 1'b1;
		repeat (n) @(posedge pclk);
		manual_trigger_key <= 1'b0;
		ext_trig_in <= 1'b0;
		@(posedge pclk);
	endtask
endmodule
`default_nettype wire

// *** test/bgo_ctrl_tb.sv ***
// self-checking bench for the burst/gate sequencer
`include "bgo_regs.vh"
`default_nettype none
module bgo_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] FREQ = 32'h1000_0000;
	localparam int HALF = 32'h8000_0000 / FREQ;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] rd;
	logic err;
	logic [7:0] lvl;
	wire logic [31:0] prdata, wave_phase;
	wire logic pready, pslverr, ext_trig_in, manual_trigger_key, osc_active;
	wire logic hold_stop_level, sync_out, trig_lamp, trig_accept;
	wire logic [7:0] stop_level;
	wire logic [1:0] square_level;
	int fails = 0;
	int total_checks = 0;
	int cyc = 0;
	int acc = 0;
	int run = 0;
	int m, d, k, lat;
	bgo_ctrl dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .ext_trig_in, .manual_trigger_key,
		.osc_active, .wave_phase, .hold_stop_level, .stop_level,
		.square_level, .sync_out, .trig_lamp, .trig_accept);
	bgo_partner u_src (.pclk, .ext_trig_in, .manual_trigger_key);
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc++;
		acc += trig_accept;
		run += osc_active;
		if (cyc == 10000) begin
			fails++;
			end_sim();
		end
	end
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, e, s);
		end
	endtask
	function automatic bit near(int a, int b);
		return a - b <= 1 && b - a <= 1;
	endfunction
	task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] dt);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {20'h0, a};
		pwdata <= dt;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// one idle edge, so the next call never re-raises psel at once
		@(posedge pclk);
	endtask
	task automatic till(input logic v, input int n, output int c);
		for (c = 0; c < n && osc_active !== v; c++)
			@(posedge pclk);
	endtask
	initial begin
		void'($urandom(77907));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk("rst_out", {sync_out, osc_active}, 2'b10);
		apb(0, `BGO_A_MARK, 0);
		chk("mark_rst", rd, `BGO_MARK_RST);
		apb(0, 12'h040, 0);
		chk("slverr", err, 1'b1);
		apb(1, `BGO_A_FREQ, FREQ);
		apb(1, `BGO_A_PHASE, $urandom() & 32'hf000_0000);
		m = 2 * $urandom_range(1, 4);
		apb(1, `BGO_A_MARK, m);
		// external source with polarity off: manual/remote only
		apb(1, `BGO_A_CTRL, 32'h0000_0029);
		u_src.pulse(0, 3);
		repeat (8) @(posedge pclk);
		chk("pol_off", acc, 0);
		run = 0;
		apb(1, `BGO_A_CMD, 1);
		apb(1, `BGO_A_CMD, 1);
		till(1, 20, k);
		till(0, 400, k);
		repeat (2) @(posedge pclk);
		chk("accepts", acc, 1);
		chk("run_len", near(run, m * HALF), 1);
		d = $urandom_range(5, 30);
		apb(1, `BGO_A_TDLY, d);
		u_src.pulse(1, 3);
		till(1, 100, lat);
		till(0, 400, k);
		for (int p = 0; p < 3; p++) begin
			acc = 0;
			apb(1, `BGO_A_CTRL, 32'h21 | (p << 6));
			u_src.pulse(0, 3);
			till(1, 100, k);
			if (p == 1)
				chk("trig_wait", near(k, lat + d), 1);
			till(0, 400, k);
			repeat (4) @(posedge pclk);
			chk("ext_pol", acc, p != 0);
		end
		apb(1, `BGO_A_CTRL, 32'h829);
		acc = 0;
		u_src.pulse(1, 3);
		repeat (10) @(posedge pclk);
		chk("other_chan", acc, 0);
		for (int w = 2; w < 4; w++) begin
			apb(1, `BGO_A_CTRL, 32'h1 | (w << 8));
			apb(1, `BGO_A_CMD, 1);
			repeat (4) @(posedge pclk);
			apb(0, `BGO_A_STAT, 0);
			chk("refused", {osc_active, rd[`BGO_S_CONFLICT]}, 2'b01);
		end
		apb(1, `BGO_A_TDLY, 0);
		apb(1, `BGO_A_TPER, 40);
		apb(1, `BGO_A_MARK, 2);
		acc = 0;
		apb(1, `BGO_A_CTRL, 32'h1);
		repeat (400) @(posedge pclk);
		apb(1, `BGO_A_CTRL, 32'h0);
		repeat (2) @(posedge pclk);
		chk("int_period", near(acc, 10), 1);
		// whole cycle, half cycle, noise; external source, polarity off
		for (int g = 0; g < 3; g++) begin
			apb(1, `BGO_A_CTRL, 32'h102b | ((g & 1) << 4) | ((g >> 1) << 9));
			repeat (50) @(posedge pclk);
			chk("gate_on", {osc_active, trig_lamp}, 2'b11);
			apb(1, `BGO_A_CTRL, 32'h002b | ((g & 1) << 4) | ((g >> 1) << 9));
			till(0, 100, k);
			chk("gate_off", k <= (2 * HALF >> g) + 2, 1);
		end
		// key held 20 clocks keeps the gate on at least 18 clocks
		run = 0;
		apb(1, `BGO_A_CTRL, 32'h002b);
		u_src.pulse(1, 20);
		till(0, 100, k);
		chk("key_gate", run >= 18, 1);
		lvl = $urandom();
		apb(1, `BGO_A_LEVEL, lvl);
		apb(1, `BGO_A_CTRL, 32'h105);
		repeat (3) @(posedge pclk);
		chk("idle_lvl", {hold_stop_level, stop_level, square_level},
			{1'b1, lvl, `BGO_SQ_STOP});
		apb(1, `BGO_A_CTRL, 32'h101);
		repeat (3) @(posedge pclk);
		chk("sq_rest", square_level == `BGO_SQ_STOP, 0);
		end_sim();
	end
endmodule
`default_nettype wire
